// >>> rtl/srsl_pkg.sv
`default_nettype none
package srsl_pkg;
   // Mask and status bit positions
   localparam int unsigned BIT_OVERFLOW = 0;
   localparam int unsigned BIT_FULL = 1;
   localparam int unsigned BIT_HALF = 2;
   localparam int unsigned BIT_DONE = 3;
   localparam int unsigned BIT_READY = 4;
   localparam int unsigned BIT_ERROR = 5;
   localparam int unsigned BIT_RQS = 6;
   localparam int unsigned NUM_COND = 6;
   localparam int unsigned NUM_ERR = 10;
   // Reset values and writable mask bits
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [5:0] COND_MASK = 6'h3f;

   // Error source indices
   localparam int unsigned ERR_TRIGGER = 0;
   localparam int unsigned ERR_SHORT_TIME = 1;
   localparam int unsigned ERR_BIG_STRING = 2;
   localparam int unsigned ERR_UNCAL = 3;
   localparam int unsigned ERR_CAL_LOCKED = 4;
   localparam int unsigned ERR_CONFLICT = 5;
   localparam int unsigned ERR_NO_REMOTE = 6;
   localparam int unsigned ERR_ILLEGAL_CMD = 7;
   localparam int unsigned ERR_ILLEGAL_OPT = 8;
   localparam int unsigned ERR_TRANSLATOR = 9;

   // Instrument conditions as levels or pulses
   typedef struct packed {
      logic overflow;
      logic buf_full;
      logic buf_half;
      logic reading_done;
      logic ready;
   } srsl_cond_t;

   // Controller-side events from the bus interface logic
   typedef struct packed {
      logic mask_write;
      logic [7:0] mask_value;
      logic device_clear;
      logic serial_poll_talk;
      logic byte_taken;
      logic error_word_query;
   } srsl_bus_t;
endpackage
`default_nettype wire

// >>> rtl/srsl_error_latch.sv
`default_nettype none
module srsl_error_latch (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Error events
   input wire logic [9:0] err_pulse,
   input wire logic clear,
   // Latched word
   output logic [9:0] err_word,
   output logic any_err
);
   // Set wins over clear so a coincident error survives the read
   logic [9:0] next_err_word;
   assign next_err_word = err_pulse | (clear ? 10'h000 : err_word);
   assign any_err = |err_word;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         err_word <= 10'h000;
      end else begin
         err_word <= next_err_word;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/srsl_status_drive.sv
`default_nettype none
module srsl_status_drive (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Poll control
   input wire logic talk,
   input wire logic [7:0] status,
   // Data lines
   output logic [7:0] dio_out,
   output logic dio_oe
);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dio_out <= 8'h00;
         dio_oe <= 1'b0;
      end else begin
         dio_out <= talk ? status : 8'h00;
         dio_oe <= talk;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/srsl_top.sv
`default_nettype none
module srsl_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Instrument conditions
   input wire srsl_pkg::srsl_cond_t cond,
   input wire logic [9:0] err_pulse,
   // Bus interface events
   input wire srsl_pkg::srsl_bus_t bus,
   // Service request line and poll data
   output logic srq,
   output logic [7:0] dio_out,
   output logic dio_oe,
   // Visible state
   output logic [7:0] status_byte,
   output logic [7:0] request_mask,
   output logic [9:0] error_word
);
   // ------------------------------------------------
   // Mask register
   // ------------------------------------------------
   logic [7:0] next_mask;
   assign next_mask = bus.device_clear ? srsl_pkg::MASK_RESET
      : bus.mask_write ? (bus.mask_value & {2'b00, srsl_pkg::COND_MASK})
      : request_mask;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         request_mask <= srsl_pkg::MASK_RESET;
      end else begin
         request_mask <= next_mask;
      end
   end

   // ------------------------------------------------
   // Error latch
   // ------------------------------------------------
   logic any_err;
   logic err_clear;
   assign err_clear = bus.error_word_query | bus.device_clear;

   srsl_error_latch u_err (
      .mclk(mclk),
      .rst_b(rst_b),
      .err_pulse(err_pulse),
      .clear(err_clear),
      .err_word(error_word),
      .any_err(any_err)
   );

   // ------------------------------------------------
   // Live condition vector
   // ------------------------------------------------
   logic [5:0] live;
   assign live[srsl_pkg::BIT_OVERFLOW] = cond.overflow;
   assign live[srsl_pkg::BIT_FULL] = cond.buf_full;
   assign live[srsl_pkg::BIT_HALF] = cond.buf_half;
   assign live[srsl_pkg::BIT_DONE] = cond.reading_done;
   assign live[srsl_pkg::BIT_READY] = cond.ready;
   assign live[srsl_pkg::BIT_ERROR] = any_err;

   // ------------------------------------------------
   // Request and freeze
   // ------------------------------------------------
   // Each cause raises a request only on its rising edge, so a standing
   // condition does not re-request right after the poll releases it.
   logic [5:0] live_d;
   logic [5:0] rise;
   logic err_armed;
   logic trigger;
   logic rqs;
   logic [5:0] held;
   logic next_rqs;
   logic [5:0] next_held;
   logic next_armed;

   assign rise = live & ~live_d;
   assign trigger = |(rise & request_mask[5:0] &
      {err_armed, 5'h1f});
   // Serial poll read clears the request; a new cause wins the cycle
   assign next_rqs = bus.device_clear ? 1'b0
      : trigger ? 1'b1
      : bus.byte_taken ? 1'b0
      : rqs;
   // Frozen while requesting, otherwise tracks the live state
   assign next_held = bus.device_clear ? 6'h00
      : (rqs && !bus.byte_taken) ? held
      : live;
   // Error requests rearm only after the error word is read or a device clear
   assign next_armed = err_clear ? 1'b1
      : (trigger && rise[srsl_pkg::BIT_ERROR] &&
         request_mask[srsl_pkg::BIT_ERROR]) ? 1'b0
      : err_armed;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         live_d <= 6'h00;
         rqs <= 1'b0;
         held <= 6'h00;
         err_armed <= 1'b1;
      end else begin
         live_d <= live;
         rqs <= next_rqs;
         held <= next_held;
         err_armed <= next_armed;
      end
   end

   // ------------------------------------------------
   // Status byte and outputs
   // ------------------------------------------------
   // While a request stands, the byte shows the snapshot taken with it
   logic [5:0] shown;
   // A second cause rising under a standing request must not unfreeze it
   assign shown = (trigger && !rqs) ? live : held;
   assign status_byte = {1'b0, rqs, shown};
   assign srq = rqs;

   srsl_status_drive u_drv (
      .mclk(mclk),
      .rst_b(rst_b),
      .talk(bus.serial_poll_talk),
      .status(status_byte),
      .dio_out(dio_out),
      .dio_oe(dio_oe)
   );
endmodule
`default_nettype wire

// >>> verification/srsl_assertions.sv
`default_nettype none
module srsl_assertions (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Watched ports
   input wire logic [9:0] err_pulse,
   input wire srsl_pkg::srsl_bus_t bus,
   input wire logic srq,
   input wire logic [7:0] dio_out,
   input wire logic dio_oe,
   input wire logic [7:0] status_byte,
   input wire logic [7:0] request_mask,
   input wire logic [9:0] error_word
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_mask_write: assert property (bus.mask_write && !bus.device_clear
      |=> request_mask == {2'h0, $past(bus.mask_value[5:0])}) else $error("mask");
   a_clear_all: assert property (bus.device_clear |=>
      request_mask == 8'h00 && !srq) else $error("device clear");
   a_rqs_bit: assert property (srq |-> status_byte[6])
      else $error("request bit");
   a_freeze_held: assert property (srq && $past(srq) &&
      !$past(bus.byte_taken) |-> $stable(status_byte[5:0]))
      else $error("frozen");
   a_poll_drive: assert property (dio_oe ==
      $past(bus.serial_poll_talk) && dio_out ==
      ($past(bus.serial_poll_talk) ? $past(status_byte) : 8'h00))
      else $error("poll drive");
   a_srq_cause: assert property ($rose(srq) |->
      |($past(request_mask) & $past(status_byte) & 8'h3f))
      else $error("request cause");
   a_err_latch: assert property (!bus.device_clear |=>
      (error_word & $past(err_pulse)) == $past(err_pulse)) else $error("error");
   a_query_clear: assert property (bus.error_word_query && !(|err_pulse)
      |=> error_word == 10'h000) else $error("query");
endmodule
bind srsl_top srsl_assertions u_chk (.mclk, .rst_b, .err_pulse, .bus, .srq,
   .dio_out, .dio_oe, .status_byte, .request_mask, .error_word);
`default_nettype wire

// >>> verification/srsl_ctrl_model.sv
`default_nettype none
module srsl_ctrl_model (
   // Clock and device side
   input wire logic mclk,
   input wire logic srq,
   input wire logic [7:0] dio_out,
   input wire logic dio_oe,
   // Poll control and captured byte
   output logic talk,
   output logic taken,
   output logic [7:0] poll_byte,
   output logic poll_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {talk, taken, poll_seen, poll_byte} = '0;
      forever begin
         @(posedge mclk);
         #1;
         if (srq === 1'b1) begin
            talk = 1'b1;
            // Look after the edge, once the new enable has settled
            do begin
               @(posedge mclk);
               #1;
            end while (dio_oe !== 1'b1);
            poll_byte = dio_out;
            taken = 1'b1;
            talk = 1'b0;
            poll_seen = 1'b1;
            @(posedge mclk);
            #1 taken = 1'b0;
            // One edge only, so each poll is compared once
            poll_seen = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/srsl_top_tb.sv
`default_nettype none
module srsl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst_b = 1'b0, mw = 1'b0, dc = 1'b0, eq = 1'b0;
   logic [4:0] c = '0;
   logic [9:0] ep = '0, ew;
   logic [7:0] mv = '0, pb, dout, sb, rm;
   logic talk, taken, seen, srq, oe;
   logic [15:0] rs = 16'h6202;
   logic [7:0] q[$];
   int error_cnt = 0, checks = 0, e;
   always #2.5 mclk = ~mclk;
   srsl_top DUT (.mclk, .rst_b, .cond(srsl_pkg::srsl_cond_t'(c)),
      .err_pulse(ep),
      .bus(srsl_pkg::srsl_bus_t'({mw, mv, dc, talk, taken, eq})),
      .srq, .dio_out(dout), .dio_oe(oe), .status_byte(sb), .request_mask(rm),
      .error_word(ew));
   srsl_ctrl_model ctl (.mclk, .srq, .dio_out(dout), .dio_oe(oe), .talk,
      .taken, .poll_byte(pb), .poll_seen(seen));
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic setm(input logic [7:0] v);
      mw = 1'b1;
      mv = v;
      tick(1);
      mw = 1'b0;
      // Let an edge pass so a following write always re-raises the strobe
      tick(1);
   endtask
   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // A poll that nobody expected always mismatches
   always @(posedge mclk) if (seen === 1'b1) begin
      if (q.size() == 0) chk({2'h0, pb}, 10'h3ff);
      else chk({2'h0, pb}, {2'h0, q.pop_front()});
   end
   initial begin
      #20000 error_cnt++;
      complete_run;
   end
   initial begin
      tick(4);
      rst_b = 1'b1;
      tick(1);
      chk(rm, 10'h000);
      for (int i = 0; i < 6; i++) begin
         rs = rs ^ (rs << 7);
         rs = rs ^ (rs >> 9);
         rs = rs ^ (rs << 8);
         e = rs[15:8] % 10;
         setm({rs[7:6], 6'h00} | (8'h01 << i));
         chk(rm, 10'h001 << i);
         q.push_back(8'h40 | (8'h01 << i));
         if (i < 5) c[4 - i] = 1'b1;
         else ep[e] = 1'b1;
         tick(1);
         ep = '0;
         for (int k = 0; k < 20 && srq !== 1'b1; k++) tick(1);
         c = 5'h1f;
         tick(6);
         chk(sb, {4'h0, i == 5, 5'h1f});
         if (i == 5) chk(ew, 10'h001 << e);
         eq = 1'b1;
         tick(1);
         eq = 1'b0;
         c = '0;
         tick(2);
         chk(ew, 10'h000);
      end
      // Second cause rises while the first request stands
      setm(8'h03);
      q.push_back(8'h41);
      c = 5'h10;
      tick(1);
      c = 5'h18;
      tick(8);
      chk(10'(q.size()), 10'h000);
      chk({9'h000, srq}, 10'h000);
      c = '0;
      dc = 1'b1;
      setm(8'h3f);
      dc = 1'b0;
      chk(rm, 10'h000);
      c = 5'h1f;
      tick(4);
      c = '0;
      setm(8'h3f);
      setm(8'h00);
      chk(rm, 10'h000);
      c = 5'h1f;
      ep = 10'h200;
      tick(1);
      ep = '0;
      tick(6);
      chk(10'(q.size()), 10'h000);
      complete_run;
   end
endmodule
`default_nettype wire
